//--- core/fxfp_conv.sv
// Double fixed-to-float converter with floating-point zero conventions
// ============================================================
// Summary of operation
// RULE1 - Low 11 bits of first operand form 12-bit characteristic, rest ignored
// RULE2 - Two storage words of signed fixed operand load a 72-bit register
// RULE3 - Negative operand complemented before normalizing; result sign remembered
// RULE4 - Over 60 significant bits: right shift to bit 59, count 1..11
// RULE5 - Under 60 significant bits: left shift to bit 59, count 1..59
// RULE6 - Positive zero operand skips characteristic work and stores zeros
// RULE7 - Count added after right shift, else subtracted; result in bits 70..60
// RULE8 - Characteristic above octal 3777 flags overflow, nothing stored
// RULE9 - Negative characteristic with underflow-zero clear flags underflow, aborts
// RULE10 - Negative characteristic with underflow-zero set stores zeros silently
// RULE11 - Normal result recomplemented if input negative, stored as two words
// RULE12 - Single word zero when bit 35 and bits 26..0 all equal
// RULE13 - Double zero when bit 71 and bits 59..0 all equal
// RULE14 - Zero first word: compat clear gives +0, in-range keeps characteristic
// RULE15 - Compat set, out of range: add/sconv +0, mul/div operand-signed zero
// RULE16 - Compress-and-load zero mantissa always stores positive zero
// RULE17 - Second-word characteristic alone never raises overflow or underflow
// RULE18 - Multiply second word above 377 packs 9-bit characteristic, sign-adjusted
// RULE19 - Zero first product word: no overflow, second word still packed
// RULE20 - Negative second-word characteristic stores zero with that word's sign
// RULE21 - Double zero mantissa stores +0, no flags, underflow-zero ignored
// RULE22 - Nonzero double, negative characteristic, underflow-zero set: store +0
`timescale 1ns/1ps
module fxfp_conv
  import fxfp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic underflowZeroSelect,
  input wire logic zeroCompatSelect,
  input wire logic convStart,
  input wire logic [WORD_W-1:0] charOperand,
  input wire logic [WORD_W-1:0] fixHi,
  input wire logic [WORD_W-1:0] fixLo,
  output logic convDone_q,
  output logic convStore_q,
  output logic convOvf_q,
  output logic convUnf_q,
  output logic [WORD_W-1:0] convResHi_q,
  output logic [WORD_W-1:0] convResLo_q,
  input wire logic zStart,
  input wire logic zDouble,
  input wire logic [2:0] zOp,
  input wire logic zOpSign,
  input wire logic [WORD_W-1:0] zWord1,
  input wire logic [WORD_W-1:0] zWord2,
  input wire logic [SP_CHAR_W-1:0] zChar1,
  input wire logic [SP_CHAR_W-1:0] zChar2,
  input wire logic zTwoWord,
  input wire logic [DP_CHAR_W-1:0] zDChar,
  output logic zDone_q,
  output logic zStore_q,
  output logic zOvf_q,
  output logic zUnf_q,
  output logic [WORD_W-1:0] zRes1_q,
  output logic [WORD_W-1:0] zRes2_q
);

  function automatic logic [CNT_W-1:0] leadOne(input logic [DBL_W-1:0] v);
    leadOne = '0;
    for (int i = 0; i < DBL_W; i++) begin
      if (v[i]) begin
        leadOne = CNT_W'(i);
      end
    end
  endfunction

  function automatic logic spZero(input logic [WORD_W-1:0] w);
    spZero = (w[SP_MANT_HI:0] == {27{w[SP_SIGN_BIT]}}); // RULE12
  endfunction

  function automatic logic dpZero(input logic [DBL_W-1:0] w);
    dpZero = (w[DP_CHAR_LO-1:0] == {60{w[DP_SIGN_BIT]}}); // RULE13
  endfunction

  function automatic logic [WORD_W-1:0] spPack(input logic [WORD_W-1:0] w, input logic [SP_CHAR_W-1:0] ch);
    spPack = {w[SP_SIGN_BIT], ch[7:0] ^ {8{w[SP_SIGN_BIT]}}, w[SP_MANT_HI:0]};
  endfunction

  // ============================================================
  // Conversion sequencer
  fxfp_cv_e cvState_q;
  logic [DBL_W-1:0] work_q;
  logic [CHAR_W-1:0] char_q;
  logic [CNT_W-1:0] cnt_q;
  logic neg_q;
  logic right_q;
  logic isZero_q;
  logic [CNT_W-1:0] leadPos;
  logic rightNeed;
  logic [CNT_W-1:0] cntD;
  logic [CHAR_W-1:0] charSum;
  logic charOvf;
  logic charNeg;
  logic [DBL_W-1:0] packWord;

  always_comb begin
    leadPos = leadOne(work_q);
    rightNeed = leadPos > NORM_POS;
    cntD = rightNeed ? leadPos - NORM_POS : NORM_POS - leadPos; // RULE4 RULE5
    charSum = right_q ? char_q + {5'h00, cnt_q} : char_q - {5'h00, cnt_q}; // RULE7
    // Only an add can pass the top; only a subtract can go below zero
    charOvf = right_q & charSum[CHAR_W-1]; // RULE8
    charNeg = ~right_q & charSum[CHAR_W-1]; // RULE9
    packWord = {1'b0, charSum[OPD_CHAR_W-1:0], work_q[DP_CHAR_LO-1:0]} ^ {DBL_W{neg_q}}; // RULE7 RULE11
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cvState_q <= CV_IDLE;
      work_q <= DBL_ZERO;
      char_q <= '0;
      cnt_q <= '0;
      neg_q <= 1'b0;
      right_q <= 1'b0;
      isZero_q <= 1'b0;
    end else begin
      case (cvState_q)
        CV_IDLE: begin
          if (convStart) begin
            char_q <= {1'b0, charOperand[OPD_CHAR_W-1:0]}; // RULE1
            neg_q <= fixHi[SP_SIGN_BIT]; // RULE3
            work_q <= {fixHi, fixLo} ^ {DBL_W{fixHi[SP_SIGN_BIT]}}; // RULE2 RULE3
            cvState_q <= CV_NORM;
          end
        end
        CV_NORM: begin
          isZero_q <= (work_q == DBL_ZERO); // RULE6
          right_q <= rightNeed;
          cnt_q <= (work_q == DBL_ZERO) ? '0 : cntD;
          work_q <= rightNeed ? work_q >> cntD : work_q << cntD; // RULE4 RULE5
          cvState_q <= CV_PACK;
        end
        CV_PACK: begin
          cvState_q <= CV_IDLE;
        end
        default: begin
          cvState_q <= CV_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Conversion results
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      convDone_q <= 1'b0;
      convStore_q <= 1'b0;
      convOvf_q <= 1'b0;
      convUnf_q <= 1'b0;
      convResHi_q <= WORD_ZERO;
      convResLo_q <= WORD_ZERO;
    end else begin
      convDone_q <= (cvState_q == CV_PACK);
      convStore_q <= 1'b0;
      convOvf_q <= 1'b0;
      convUnf_q <= 1'b0;
      if (cvState_q == CV_PACK) begin
        if (isZero_q) begin
          convStore_q <= 1'b1; // RULE6
          convResHi_q <= WORD_ZERO;
          convResLo_q <= WORD_ZERO;
        end else if (charOvf) begin
          convOvf_q <= 1'b1; // RULE8
        end else if (charNeg && !underflowZeroSelect) begin
          convUnf_q <= 1'b1; // RULE9
        end else if (charNeg) begin
          convStore_q <= 1'b1; // RULE10
          convResHi_q <= WORD_ZERO;
          convResLo_q <= WORD_ZERO;
        end else begin
          convStore_q <= 1'b1; // RULE11
          convResHi_q <= packWord[DBL_W-1:WORD_W];
          convResLo_q <= packWord[WORD_W-1:0];
        end
      end
    end
  end

  // ============================================================
  // Zero-convention result shaping
  logic [WORD_W-1:0] r1;
  logic [WORD_W-1:0] r2;
  logic st;
  logic ov;
  logic un;
  logic z1;
  logic [DBL_W-1:0] dw;
  logic c1Neg;
  logic c1Big;
  logic c2Neg;
  logic c2Big;
  logic isMd;

  always_comb begin
    r1 = WORD_ZERO;
    r2 = WORD_ZERO;
    st = 1'b1;
    ov = 1'b0;
    un = 1'b0;
    dw = {zWord1, zWord2};
    z1 = spZero(zWord1);
    c1Neg = zChar1[SP_CHAR_W-1];
    c1Big = !c1Neg && (zChar1 > SP_CHAR_MAX);
    c2Neg = zChar2[SP_CHAR_W-1];
    c2Big = !c2Neg && (zChar2 > SP_CHAR_MAX);
    isMd = (zOp == OP_MUL) || (zOp == OP_DIV);
    if (zDouble) begin
      if (dpZero(dw)) begin
        r1 = WORD_ZERO; // RULE21
      end else if (zDChar[DP_CHAR_W-1]) begin
        st = underflowZeroSelect; // RULE22
        un = !underflowZeroSelect;
      end else if (zDChar[DP_CHAR_W-2]) begin
        st = 1'b0;
        ov = 1'b1;
      end else begin
        dw = {dw[DP_SIGN_BIT], zDChar[OPD_CHAR_W-1:0] ^ {11{dw[DP_SIGN_BIT]}}, dw[DP_CHAR_LO-1:0]};
        r1 = dw[DBL_W-1:WORD_W];
        r2 = dw[WORD_W-1:0];
      end
    end else begin
      if (z1) begin
        if (zOp == OP_COMPRESS || !zeroCompatSelect) begin
          r1 = WORD_ZERO; // RULE14 RULE16
        end else if (!c1Neg && !c1Big) begin
          r1 = spPack({36{zWord1[SP_SIGN_BIT]}}, zChar1); // RULE14
        end else if (isMd) begin
          r1 = {WORD_W{zOpSign}}; // RULE15
        end else begin
          r1 = WORD_ZERO; // RULE15
        end
      end else if (c1Neg) begin
        st = 1'b0;
        un = 1'b1;
      end else if (c1Big) begin
        st = 1'b0;
        ov = 1'b1;
      end else begin
        r1 = spPack(zWord1, zChar1);
      end
      // Second word never raises a flag of its own
      if (zTwoWord) begin
        if (c2Neg) begin
          r2 = {WORD_W{zWord2[SP_SIGN_BIT]}}; // RULE17 RULE20
        end else if (c2Big && zOp == OP_MUL) begin
          r2 = {zWord2[SP_SIGN_BIT:SP_SIGN_BIT] == 1'b1 ? ~zChar2[8:0] : zChar2[8:0],
                zWord2[SP_MANT_HI:0]}; // RULE18 RULE19
        end else begin
          r2 = spPack(zWord2, zChar2);
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      zDone_q <= 1'b0;
      zStore_q <= 1'b0;
      zOvf_q <= 1'b0;
      zUnf_q <= 1'b0;
      zRes1_q <= WORD_ZERO;
      zRes2_q <= WORD_ZERO;
    end else begin
      zDone_q <= zStart;
      zStore_q <= zStart & st;
      zOvf_q <= zStart & ov;
      zUnf_q <= zStart & un;
      if (zStart) begin
        zRes1_q <= r1;
        zRes2_q <= r2;
      end
    end
  end

  // ============================================================
  // Checks
  conv_latency_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (cvState_q == CV_IDLE && convStart) |-> ##3 convDone_q) // RULE2
    else $error("conversion did not finish in three cycles");
  ovf_nostore_a: assert property (@(posedge mclk) disable iff (sys_rst)
    convOvf_q |-> !convStore_q && convDone_q) // RULE8
    else $error("overflow with a stored result");
  unf_nostore_a: assert property (@(posedge mclk) disable iff (sys_rst)
    convUnf_q |-> !convStore_q && !underflowZeroSelect) // RULE9
    else $error("underflow reported wrongly");
  zero_in_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (cvState_q == CV_IDLE && convStart && ({fixHi, fixLo} == DBL_ZERO))
    |-> ##3 (convStore_q && convResHi_q == WORD_ZERO && convResLo_q == WORD_ZERO)) // RULE6
    else $error("zero operand did not store zeros");
  norm_pos_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (cvState_q == CV_PACK && !isZero_q) |-> work_q[DP_CHAR_LO-1] && work_q[DBL_W-1:DP_CHAR_LO] == '0) // RULE4 RULE5
    else $error("mantissa not normalized to bit 59");
  sign_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (convStore_q && convResHi_q != WORD_ZERO) |-> convResHi_q[SP_SIGN_BIT] == neg_q) // RULE11
    else $error("result sign differs from operand sign");
  compress_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (zStart && !zDouble && zOp == OP_COMPRESS && spZero(zWord1)) |=> zRes1_q == WORD_ZERO) // RULE16
    else $error("compress zero not positive");
  dp_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (zStart && zDouble && dpZero({zWord1, zWord2}))
    |=> (zStore_q && !zOvf_q && !zUnf_q && zRes1_q == WORD_ZERO && zRes2_q == WORD_ZERO)) // RULE21
    else $error("double zero mishandled");
  sp_zero_flags_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (zStart && !zDouble && spZero(zWord1)) |=> !zOvf_q && !zUnf_q) // RULE17 RULE19
    else $error("flag raised for zero first word");
  dp_uzs_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (zStart && zDouble && underflowZeroSelect && zDChar[DP_CHAR_W-1]) |=> !zUnf_q && zRes1_q == WORD_ZERO) // RULE22
    else $error("underflow-zero select not honoured");
  cv_ovf_c: cover property (@(posedge mclk) disable iff (sys_rst) convOvf_q);
  cv_uzs_c: cover property (@(posedge mclk) disable iff (sys_rst) convStore_q && underflowZeroSelect);
  cv_neg_c: cover property (@(posedge mclk) disable iff (sys_rst) convStore_q && neg_q && !isZero_q);
  z_mul2_c: cover property (@(posedge mclk) disable iff (sys_rst) zStart && zTwoWord && zOp == OP_MUL && c2Big);

endmodule // fxfp_conv

//--- core/fxfp_pkg.sv
// Constants and types shared by the fixed-to-float converter and zero-convention unit
package fxfp_pkg;
  localparam int unsigned WORD_W = 36;
  localparam int unsigned DBL_W = 72;
  localparam int unsigned CHAR_W = 12;
  localparam int unsigned OPD_CHAR_W = 11;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned SP_CHAR_W = 10;
  localparam int unsigned DP_CHAR_W = 13;
  localparam int unsigned DP_SIGN_BIT = 71;
  localparam int unsigned DP_CHAR_HI = 70;
  localparam int unsigned DP_CHAR_LO = 60;
  localparam int unsigned SP_SIGN_BIT = 35;
  localparam int unsigned SP_MANT_HI = 26;
  localparam logic [CNT_W-1:0] NORM_POS = 7'h3b;
  localparam logic [SP_CHAR_W-1:0] SP_CHAR_MAX = 10'h0ff;
  localparam logic [WORD_W-1:0] WORD_ZERO = 36'h000000000;
  localparam logic [DBL_W-1:0] DBL_ZERO = 72'h000000000000000000;
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_NORM = 2'b01,
    CV_PACK = 2'b10
  } fxfp_cv_e;
  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_ADDNEG = 3'b001,
    OP_MUL = 3'b010,
    OP_DIV = 3'b011,
    OP_SCONV = 3'b100,
    OP_COMPRESS = 3'b101
  } fxfp_op_e;
endpackage

//--- dv/fxfp_creg_model.sv
// Control register pair model that takes the converter's stored double words
`timescale 1ns/1ps
module fxfp_creg_model
  import fxfp_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [WORD_W-1:0] wrHi,
  input wire logic [WORD_W-1:0] wrLo,
  output logic [DBL_W-1:0] regPair_q
);
  // ============================================================
  // Two consecutive control registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regPair_q <= DBL_ZERO;
    end else if (wrEn) begin
      regPair_q <= {wrHi, wrLo};
    end
  end
endmodule // fxfp_creg_model

//--- dv/tb_fxfp_conv.sv
// Self-checking bench for the converter and zero shaper
`timescale 1ns/1ps
module tb_fxfp_conv;
  import fxfp_pkg::*;
  logic mclk, sys_rst, underflowZeroSelect, zeroCompatSelect, convStart, zStart, zDouble, zOpSign, zTwoWord;
  logic [WORD_W-1:0] charOperand, fixHi, fixLo, zWord1, zWord2, convResHi_q, convResLo_q, zRes1_q, zRes2_q;
  logic [2:0] zOp;
  logic [SP_CHAR_W-1:0] zChar1, zChar2;
  logic [DP_CHAR_W-1:0] zDChar;
  logic convDone_q, convStore_q, convOvf_q, convUnf_q, zDone_q, zStore_q, zOvf_q, zUnf_q;
  logic [DBL_W-1:0] regPair_q, lastStore, v;
  int err_total, n_tests, cycles, seed, sh;

  fxfp_conv fxfp_conv_i (.mclk, .sys_rst, .underflowZeroSelect, .zeroCompatSelect, .convStart, .charOperand,
    .fixHi, .fixLo, .convDone_q, .convStore_q, .convOvf_q, .convUnf_q, .convResHi_q, .convResLo_q, .zStart,
    .zDouble, .zOp, .zOpSign, .zWord1, .zWord2, .zChar1, .zChar2, .zTwoWord, .zDChar, .zDone_q, .zStore_q,
    .zOvf_q, .zUnf_q, .zRes1_q, .zRes2_q);
  fxfp_creg_model fxfp_creg_model_i (.mclk, .sys_rst, .wrEn(convStore_q), .wrHi(convResHi_q),
    .wrLo(convResLo_q), .regPair_q);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ============================================================
  // Checking helpers
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check_word(input string nm, input logic [DBL_W-1:0] e, input logic [DBL_W-1:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Returns {store, ovf, unf, result}
  function automatic logic [DBL_W+2:0] conv_ref(input logic [WORD_W-1:0] co, input logic [DBL_W-1:0] x,
      input logic uz);
    logic [CHAR_W-1:0] c;
    logic [DBL_W-1:0] m;
    logic neg;
    int p;
    c = {1'b0, co[OPD_CHAR_W-1:0]};
    neg = x[DP_SIGN_BIT];
    m = neg ? ~x : x;
    if (m == DBL_ZERO) return {3'b100, DBL_ZERO};
    p = 0;
    for (int i = 0; i < DBL_W; i++) if (m[i]) p = i;
    if (p > 59) begin
      m = m >> (p - 59);
      c = c + CHAR_W'(p - 59);
      if (c[11]) return {3'b010, DBL_ZERO};
    end else begin
      m = m << (59 - p);
      c = c - CHAR_W'(59 - p);
      if (c[11]) return uz ? {3'b100, DBL_ZERO} : {3'b001, DBL_ZERO};
    end
    m = {1'b0, c[10:0], m[59:0]};
    return {3'b100, neg ? ~m : m};
  endfunction

  // ============================================================
  // Operation drivers
  task automatic run_conv(input logic [WORD_W-1:0] co, input logic [DBL_W-1:0] x, input logic uz,
      input logic hold);
    logic [DBL_W+2:0] e;
    int k;
    e = conv_ref(co, x, uz);
    charOperand = co;
    {fixHi, fixLo} = x;
    underflowZeroSelect = uz;
    convStart = 1'b1;
    @(posedge mclk);
    #2;
    if (!hold) convStart = 1'b0;
    k = 0;
    while (convDone_q !== 1'b1 && k < 6) begin
      @(posedge mclk);
      #2;
      convStart = 1'b0;
      k++;
    end
    check_bit("conv done", 1'b1, convDone_q);
    check_bit("conv store", e[74], convStore_q);
    check_bit("conv ovf", e[73], convOvf_q);
    check_bit("conv unf", e[72], convUnf_q);
    if (e[74]) lastStore = e[DBL_W-1:0];
    @(posedge mclk);
    #2;
    check_word("creg pair", lastStore, regPair_q);
    check_bit("single done", 1'b0, convDone_q);
  endtask

  task automatic run_z(input logic [7:0] ctl, input logic [WORD_W-1:0] w1, w2,
      input logic [SP_CHAR_W-1:0] c1, c2, input logic [DP_CHAR_W-1:0] dc, input logic [2:0] ef,
      input logic [DBL_W-1:0] er);
    {underflowZeroSelect, zeroCompatSelect, zDouble, zOp, zOpSign, zTwoWord} = ctl;
    zWord1 = w1;
    zWord2 = w2;
    zChar1 = c1;
    zChar2 = c2;
    zDChar = dc;
    zStart = 1'b1;
    @(posedge mclk);
    #2;
    zStart = 1'b0;
    check_bit("z done", 1'b1, zDone_q);
    check_word("z flags", {69'h0, ef}, {69'h0, zStore_q, zOvf_q, zUnf_q});
    if (ef[2]) check_word("z result", er, (zDouble | zTwoWord) ? {zRes1_q, zRes2_q} : {zRes1_q, WORD_ZERO});
  endtask

  // ============================================================
  // Main sequence
  initial begin
    seed = 32'hda8d557c;
    {underflowZeroSelect, zeroCompatSelect, convStart, zStart, zDouble, zOpSign, zTwoWord, zOp} = 10'h000;
    {charOperand, fixHi, fixLo, zWord1, zWord2} = 180'h0;
    {zChar1, zChar2, zDChar} = 33'h0;
    lastStore = DBL_ZERO;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    sys_rst = 1'b0;
    run_conv(36'h000000000, 72'h000000000000000000, 1'b0, 1'b0);
    run_conv(36'h000000000, 72'hffffffffffffffffff, 1'b0, 1'b0);
    run_conv(36'habcdef400, 72'h000800000000000000, 1'b0, 1'b0);
    run_conv(36'h0000007ff, 72'h7fffffffffffffffff, 1'b0, 1'b1);
    run_conv(36'h0000007f0, 72'h7fffffffffffffffff, 1'b0, 1'b0);
    run_conv(36'h000000000, 72'h000000000000000001, 1'b0, 1'b0);
    run_conv(36'h000000000, 72'h000000000000000001, 1'b1, 1'b0);
    run_conv(36'h00000003b, 72'hfffffffffffffffffe, 1'b0, 1'b0);
    for (int n = 0; n < 200; n++) begin
      v = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      sh = $unsigned($random(seed)) % 72;
      v = v >> sh;
      if ($random(seed) & 1) v = ~v;
      run_conv({4'($random(seed)), 32'($random(seed))}, v, 1'($random(seed)), 1'($random(seed)));
    end
    for (int op = 0; op < 6; op++) begin
      run_z({3'b000, 3'(op), 2'b10}, 36'hfffffffff, WORD_ZERO, 10'h005, 10'h000, 13'h0000, 3'b100, DBL_ZERO);
    end
    run_z(8'b01000010, 36'h807ffffff, WORD_ZERO, 10'h005, 10'h000, 13'h0000, 3'b100,
      {36'hfd7ffffff, WORD_ZERO});
    run_z(8'b01001010, WORD_ZERO, WORD_ZERO, 10'h100, 10'h000, 13'h0000, 3'b100, {36'hfffffffff, WORD_ZERO});
    run_z(8'b01000010, WORD_ZERO, WORD_ZERO, 10'h3f0, 10'h000, 13'h0000, 3'b100, DBL_ZERO);
    run_z(8'b01010110, 36'hfffffffff, WORD_ZERO, 10'h005, 10'h000, 13'h0000, 3'b100, DBL_ZERO);
    run_z(8'b00101010, 36'hfffffffff, 36'hfffffffff, 10'h000, 10'h000, 13'h0fff, 3'b100, DBL_ZERO);
    run_z(8'b10100000, 36'h000800000, WORD_ZERO, 10'h000, 10'h000, 13'h1ff0, 3'b100, DBL_ZERO);
    run_z(8'b00100000, 36'h000800000, WORD_ZERO, 10'h000, 10'h000, 13'h1ff0, 3'b001, DBL_ZERO);
    run_z(8'b00000011, WORD_ZERO, 36'hff8000000, 10'h005, 10'h3f0, 13'h0000, 3'b100,
      {WORD_ZERO, 36'hfffffffff});
    run_z(8'b00001001, WORD_ZERO, 36'hff8000000, 10'h100, 10'h1a5, 13'h0000, 3'b100,
      {WORD_ZERO, 36'h2d0000000});
    run_z(8'b00100000, 36'h000800000, WORD_ZERO, 10'h000, 10'h000, 13'h0400, 3'b100,
      {36'h400800000, WORD_ZERO});
    run_z(8'b00100000, 36'h000800000, WORD_ZERO, 10'h000, 10'h000, 13'h0800, 3'b010, DBL_ZERO);
    report_and_stop();
  end
endmodule // tb_fxfp_conv
